// ---- src/irq_status_defines.svh ----
`ifndef IRQ_STATUS_DEFINES_SVH
`define IRQ_STATUS_DEFINES_SVH
// register offsets
`define OFS_SECONDARY_FLAGS 8'h05
`define OFS_IRQ_ENABLE_MASK 8'h06
`define OFS_IRQ_REQUEST_FLAGS 8'h07
// reset values
`define RST_SECONDARY_FLAGS 8'h60
`define RST_IRQ_ENABLE_MASK 6'h00
`define RST_IRQ_REQUEST_FLAGS 6'h00
// field positions
`define BIT_SET_SELECT 7
`define BIT_COUNTDOWN_ACTIVE 7
`define BIT_NVM_DONE 6
`define BIT_CHECKSUM_DONE 5
`define BIT_COUNTDOWN 5
`define BIT_TRANSMIT 4
`define BIT_RECEIVE 3
`define BIT_COMMAND 2
`define BIT_FIFO_HIGH 1
`define BIT_FIFO_LOW 0
// fifo
`define FIFO_DEPTH 7'h40
`endif

// ---- src/irq_status_pkg.sv ----
package irq_status_pkg;
	typedef struct packed {
		logic countdown;
		logic transmit;
		logic receive;
		logic command;
		logic fifo_high;
		logic fifo_low;
	} irq_vec_t;

	typedef struct packed {
		logic countdown_active;
		logic nvm_program_done;
		logic checksum_done;
		logic [2:0] final_byte_valid_bits;
	} sec_status_t;

	typedef struct packed {
		logic transceive_tx_done;
		logic auth_tx_done;
		logic nvm_write_done;
		logic checksum_cmd_done;
	} tx_events_t;

	typedef enum logic [1:0] {
		CMD_QUIET,
		CMD_RUNNING
	} cmd_state_t;
endpackage

// ---- src/fifo_alert.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irq_status_defines.svh"
// ==========================================================
// fifo alert comparators and rising-edge detection
module fifo_alert #(
	parameter int CNT_W = 7
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// fifo state
	input wire logic [CNT_W-1:0] fifo_byte_count_i,
	input wire logic [CNT_W-1:0] fifo_threshold_i,
	// alerts
	output logic fifo_nearly_full_o,
	output logic fifo_nearly_empty_o,
	output logic high_rise_o,
	output logic low_rise_o
);
	logic [CNT_W-1:0] free_space;
	logic high_ff;
	logic low_ff;

	assign free_space = CNT_W'(`FIFO_DEPTH) - fifo_byte_count_i;
	assign fifo_nearly_full_o = (free_space <= fifo_threshold_i);
	assign fifo_nearly_empty_o = (fifo_byte_count_i <= fifo_threshold_i);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			high_ff <= 1'b0;
			low_ff <= 1'b0;
		end else begin
			high_ff <= fifo_nearly_full_o;
			low_ff <= fifo_nearly_empty_o;
		end
	end

	assign high_rise_o = fifo_nearly_full_o & ~high_ff;
	assign low_rise_o = fifo_nearly_empty_o & ~low_ff;
endmodule
`default_nettype wire

// ---- src/reader_irq_and_status.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irq_status_defines.svh"
module reader_irq_and_status #(
	parameter int CNT_W = 7
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// event sources
	input wire irq_status_pkg::sec_status_t sec_status_i,
	input wire logic countdown_zero_i,
	input wire irq_status_pkg::tx_events_t tx_events_i,
	input wire logic receive_end_i,
	input wire logic command_to_idle_i,
	input wire logic command_by_cpu_i,
	input wire logic unknown_command_i,
	input wire logic [CNT_W-1:0] fifo_byte_count_i,
	input wire logic [CNT_W-1:0] fifo_threshold_i,
	// outputs
	output irq_status_pkg::irq_vec_t enable_o,
	output irq_status_pkg::irq_vec_t request_o,
	output logic primary_irq_o,
	output logic fifo_nearly_full_o,
	output logic fifo_nearly_empty_o,
	output logic irq_o
);
	import irq_status_pkg::*;

	// ==========================================================
	// helpers
	function automatic irq_vec_t set_clear(input irq_vec_t cur, input logic [7:0] wd);
		irq_vec_t marks;
		marks = irq_vec_t'(wd[5:0]);
		if (wd[`BIT_SET_SELECT]) begin
			set_clear = cur | marks;
		end else begin
			set_clear = cur & ~marks;
		end
	endfunction

	irq_vec_t enable_ff;
	irq_vec_t nxt_enable;
	irq_vec_t request_ff;
	irq_vec_t nxt_request;
	irq_vec_t events;
	irq_vec_t written;
	logic wr_enable;
	logic wr_request;
	logic high_rise;
	logic low_rise;
	logic [7:0] nxt_rdata;
	logic [7:0] rdata_ff;

	// ==========================================================
	// fifo alert detection
	fifo_alert #(
		.CNT_W(CNT_W)
	) u_alert (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.fifo_byte_count_i(fifo_byte_count_i),
		.fifo_threshold_i(fifo_threshold_i),
		.fifo_nearly_full_o(fifo_nearly_full_o),
		.fifo_nearly_empty_o(fifo_nearly_empty_o),
		.high_rise_o(high_rise),
		.low_rise_o(low_rise)
	);

	assign wr_enable = wr_i && (addr_i == `OFS_IRQ_ENABLE_MASK);
	assign wr_request = wr_i && (addr_i == `OFS_IRQ_REQUEST_FLAGS);

	// ==========================================================
	// enable mask: set/clear only
	always_comb begin
		nxt_enable = enable_ff;
		if (wr_enable) begin
			nxt_enable = set_clear(enable_ff, wdata_i);
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			enable_ff <= irq_vec_t'(`RST_IRQ_ENABLE_MASK);
		end else begin
			enable_ff <= nxt_enable;
		end
	end

	// ==========================================================
	// request flags: events win over a clear in the same cycle
	always_comb begin
		events.countdown = countdown_zero_i;
		events.transmit = |tx_events_i;
		events.receive = receive_end_i;
		events.command = (command_to_idle_i && !command_by_cpu_i)
			|| unknown_command_i;
		events.fifo_high = high_rise;
		events.fifo_low = low_rise;
	end

	always_comb begin
		written = request_ff;
		if (wr_request) begin
			written = set_clear(request_ff, wdata_i);
		end
		nxt_request = written | events;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			request_ff <= irq_vec_t'(`RST_IRQ_REQUEST_FLAGS);
		end else begin
			request_ff <= nxt_request;
		end
	end

	// ==========================================================
	// interrupt output
	assign enable_o = enable_ff;
	assign request_o = request_ff;
	assign primary_irq_o = |(request_ff & enable_ff);
	assign irq_o = |(request_ff & enable_ff);

	// ==========================================================
	// read mux, registered
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				`OFS_SECONDARY_FLAGS: begin
					nxt_rdata[`BIT_COUNTDOWN_ACTIVE] = sec_status_i.countdown_active;
					nxt_rdata[`BIT_NVM_DONE] = sec_status_i.nvm_program_done;
					nxt_rdata[`BIT_CHECKSUM_DONE] = sec_status_i.checksum_done;
					nxt_rdata[2:0] = sec_status_i.final_byte_valid_bits;
				end
				`OFS_IRQ_ENABLE_MASK: begin
					nxt_rdata[5:0] = enable_ff;
				end
				`OFS_IRQ_REQUEST_FLAGS: begin
					nxt_rdata[5:0] = request_ff;
				end
				default: begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata_o = rdata_ff;

	// ==========================================================
	// checks: enable mask writes
	a_enable_set: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_enable && wdata_i[7] |=> ((enable_o & irq_vec_t'($past(wdata_i[5:0])))
		== irq_vec_t'($past(wdata_i[5:0]))))
		else $error("enable set write failed");

	a_enable_clear: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_enable && !wdata_i[7]
		|=> ((enable_o & irq_vec_t'($past(wdata_i[5:0]))) == 6'h00))
		else $error("enable clear write failed");

	a_enable_unmarked: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_enable
		|=> (((enable_o ^ $past(enable_o)) & ~irq_vec_t'($past(wdata_i[5:0]))) == 6'h00))
		else $error("unmarked enable bit changed");

	a_enable_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		!wr_enable |=> $stable(enable_o))
		else $error("enable changed without write");

	// ==========================================================
	// checks: request flag writes
	a_request_set: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_request && wdata_i[7] |=> ((request_o & irq_vec_t'($past(wdata_i[5:0])))
		== irq_vec_t'($past(wdata_i[5:0]))))
		else $error("request set write failed");

	a_request_clear: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_request && !wdata_i[7] && (events == 6'h00)
		|=> ((request_o & irq_vec_t'($past(wdata_i[5:0]))) == 6'h00))
		else $error("request clear write failed");

	a_request_unmarked: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_request && (events == 6'h00)
		|=> (((request_o ^ $past(request_o)) & ~irq_vec_t'($past(wdata_i[5:0]))) == 6'h00))
		else $error("unmarked request bit changed");

	a_request_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		!wr_request && (events == 6'h00) |=> $stable(request_o))
		else $error("request changed without cause");

	// ==========================================================
	// checks: event sources
	a_timer_event: assert property (@(posedge clock_i) disable iff (rst_i)
		countdown_zero_i |=> request_o.countdown)
		else $error("timer flag not set");

	a_tx_event: assert property (@(posedge clock_i) disable iff (rst_i)
		(tx_events_i != 4'h0) |=> request_o.transmit)
		else $error("transmit flag not set");

	a_rx_event: assert property (@(posedge clock_i) disable iff (rst_i)
		receive_end_i |=> request_o.receive)
		else $error("receive flag not set");

	a_cmd_event: assert property (@(posedge clock_i) disable iff (rst_i)
		command_to_idle_i && !command_by_cpu_i |=> request_o.command)
		else $error("command flag not set");

	a_unknown_cmd: assert property (@(posedge clock_i) disable iff (rst_i)
		unknown_command_i |=> request_o.command)
		else $error("unknown command flag not set");

	a_idle_cpu: assert property (@(posedge clock_i) disable iff (rst_i)
		command_by_cpu_i && !unknown_command_i && !request_o.command && !wr_request
		|=> !request_o.command)
		else $error("cpu idle set flag");

	a_high_rise: assert property (@(posedge clock_i) disable iff (rst_i)
		$rose(fifo_nearly_full_o) |=> request_o.fifo_high)
		else $error("high alert flag not set");

	a_low_rise: assert property (@(posedge clock_i) disable iff (rst_i)
		$rose(fifo_nearly_empty_o) |=> request_o.fifo_low)
		else $error("low alert flag not set");

	a_alert_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
		request_o.fifo_low && !wr_request |=> request_o.fifo_low)
		else $error("low alert flag dropped");

	a_high_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
		request_o.fifo_high && !wr_request |=> request_o.fifo_high)
		else $error("high alert flag dropped");

	a_full_level: assert property (@(posedge clock_i) disable iff (rst_i)
		(fifo_byte_count_i <= `FIFO_DEPTH) |-> fifo_nearly_full_o
		== ((32'(fifo_byte_count_i) + 32'(fifo_threshold_i)) >= 32'(`FIFO_DEPTH)))
		else $error("high alert level wrong");

	// ==========================================================
	// checks: interrupt pin and primary status
	a_irq_pin: assert property (@(posedge clock_i) disable iff (rst_i)
		irq_o == |(request_o & enable_o))
		else $error("irq pin mismatch");

	a_pin_gate: assert property (@(posedge clock_i) disable iff (rst_i)
		request_o.countdown && enable_o.countdown |-> irq_o)
		else $error("enabled timer request not on pin");

	a_rx_masked: assert property (@(posedge clock_i) disable iff (rst_i)
		request_o.receive && ((request_o & enable_o) == 6'h00) |-> !irq_o)
		else $error("masked receive request on pin");

	a_primary_irq: assert property (@(posedge clock_i) disable iff (rst_i)
		request_o.receive && enable_o.receive |-> primary_irq_o)
		else $error("primary status bit not set");

	// ==========================================================
	// checks: register reads
	a_status_read: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_i && addr_i == `OFS_SECONDARY_FLAGS |=> rdata_o[4:3] == 2'h0
		&& rdata_o[7] == $past(sec_status_i.countdown_active))
		else $error("status read wrong");

	a_status_bits: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_i && addr_i == `OFS_SECONDARY_FLAGS
		|=> rdata_o[6] == $past(sec_status_i.nvm_program_done)
		&& rdata_o[5] == $past(sec_status_i.checksum_done)
		&& rdata_o[2:0] == $past(sec_status_i.final_byte_valid_bits))
		else $error("status bits read wrong");

	a_enable_read: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_i && addr_i == `OFS_IRQ_ENABLE_MASK
		|=> rdata_o == {2'h0, $past(enable_o)})
		else $error("enable read wrong");

	a_request_read: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_i && addr_i == `OFS_IRQ_REQUEST_FLAGS
		|=> rdata_o == {2'h0, $past(request_o)})
		else $error("request read wrong");

	a_unmapped_read: assert property (@(posedge clock_i) disable iff (rst_i)
		rd_i && (addr_i < `OFS_SECONDARY_FLAGS || addr_i > `OFS_IRQ_REQUEST_FLAGS)
		|=> rdata_o == 8'h00)
		else $error("unmapped read not zero");

	a_read_idle: assert property (@(posedge clock_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data without strobe");

	// ==========================================================
	// main scenarios
	c_irq_raise: cover property (@(posedge clock_i) disable iff (rst_i) $rose(irq_o));

	c_ack: cover property (@(posedge clock_i) disable iff (rst_i)
		request_o.receive ##1 !request_o.receive);

	c_high_alert: cover property (@(posedge clock_i) disable iff (rst_i)
		$rose(request_o.fifo_high));

	c_unknown_cmd: cover property (@(posedge clock_i) disable iff (rst_i)
		unknown_command_i ##1 request_o.command);

	c_event_beats_clear: cover property (@(posedge clock_i) disable iff (rst_i)
		wr_request && !wdata_i[7] && wdata_i[3] && receive_end_i);
endmodule
`default_nettype wire

// ---- tb/cpu_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// processor side of the parallel register port
module cpu_bus_model (
	// clock
	input wire logic clock_i,
	// register port
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		wr_o = 1'h0;
		rd_o = 1'h0;
		wdata_o = 8'h00;
	end

	// mask bits are only ever changed by set/clear writes
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'h1;
		@(negedge clock_i);
		wr_o = 1'h0;
		wdata_o = ~d;
	endtask

	// read data stands one cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock_i);
		addr_o = a;
		rd_o = 1'h1;
		@(negedge clock_i);
		rd_o = 1'h0;
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	import irq_status_pkg::*;
	typedef struct packed {
		logic [7:0] ev;
		logic cpu;
		logic [5:0] exp;
	} row_t;
	// ==========================================================
	// signals
	logic clock_i;
	logic rst_i;
	logic [7:0] addr, wdata, rdata, rv;
	logic wr, rd, cz, rx, idle, by_cpu, unk, prim, full, empty, irq;
	sec_status_t sec;
	tx_events_t txe;
	logic [6:0] cnt, thr;
	irq_vec_t en, rq;
	int failures = 0;
	int comparisons = 0;
	// event order: countdown, four transmit kinds, receive, idle, idle by cpu, unknown
	row_t rows [9] = '{'{8'h80, 1'h0, 6'h20}, '{8'h40, 1'h0, 6'h10},
		'{8'h20, 1'h0, 6'h10}, '{8'h10, 1'h0, 6'h10}, '{8'h08, 1'h0, 6'h10},
		'{8'h04, 1'h0, 6'h08}, '{8'h02, 1'h0, 6'h04}, '{8'h02, 1'h1, 6'h00},
		'{8'h01, 1'h0, 6'h04}};

	cpu_bus_model i_cpu (.clock_i(clock_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
		.wdata_o(wdata), .rdata_i(rdata));

	reader_irq_and_status i_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr),
		.wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .sec_status_i(sec),
		.countdown_zero_i(cz), .tx_events_i(txe), .receive_end_i(rx),
		.command_to_idle_i(idle), .command_by_cpu_i(by_cpu), .unknown_command_i(unk),
		.fifo_byte_count_i(cnt), .fifo_threshold_i(thr), .enable_o(en),
		.request_o(rq), .primary_irq_o(prim), .fifo_nearly_full_o(full),
		.fifo_nearly_empty_o(empty), .irq_o(irq));

	// ==========================================================
	// checking
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		i_cpu.rd_reg(a, rv);
		chk(rv, e);
	endtask

	task automatic finish_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		clock_i = 1'h0;
		forever #25 clock_i = ~clock_i;
	end

	initial begin
		#100000;
		failures++;
		finish_test;
	end

	task automatic step(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	// ==========================================================
	// stimulus
	initial begin
		rst_i = 1'h1;
		sec = 6'h18;
		{cz, txe, rx, idle, unk} = 8'h00;
		by_cpu = 1'h0;
		cnt = 7'h20;
		thr = 7'h00;
		repeat (6) @(posedge clock_i);
		step(1);
		chk({7'h0, irq}, 8'h00);
		rst_i = 1'h0;
		rd_chk(8'h05, 8'h60);
		rd_chk(8'h07, 8'h00);
		sec = 6'h25;
		rd_chk(8'h05, 8'h85);
		foreach (rows[k]) begin
			step(1);
			{cz, txe, rx, idle, unk} = rows[k].ev;
			by_cpu = rows[k].cpu;
			step(1);
			{cz, txe, rx, idle, unk} = 8'h00;
			chk({2'h0, rq}, {2'h0, rows[k].exp});
			i_cpu.wr_reg(8'h07, 8'h3F);
		end
		i_cpu.wr_reg(8'h06, 8'hFF);
		rd_chk(8'h06, 8'h3F);
		i_cpu.wr_reg(8'h06, 8'h4A);
		chk({2'h0, en}, 8'h35);
		i_cpu.wr_reg(8'h06, 8'h80);
		chk({2'h0, en}, 8'h35);
		rd_chk(8'h09, 8'h00);
		i_cpu.wr_reg(8'h07, 8'hBF);
		chk({prim, irq, rq}, 8'hFF);
		i_cpu.wr_reg(8'h07, 8'h35);
		chk({prim, irq, rq}, 8'h0A);
		i_cpu.wr_reg(8'h06, 8'h82);
		chk({prim, irq, rq}, 8'hCA);
		i_cpu.wr_reg(8'h07, 8'h3F);
		thr = 7'h04;
		cnt = 7'h3B;
		step(1);
		chk({full, empty, rq}, 8'h00);
		cnt = 7'h3C;
		step(2);
		chk({full, empty, rq}, 8'h82);
		cnt = 7'h05;
		step(1);
		chk({full, empty, rq}, 8'h02);
		cnt = 7'h04;
		step(2);
		chk({full, empty, rq}, 8'h43);
		cnt = 7'h20;
		step(1);
		chk({prim, irq, rq}, 8'hC3);
		// a receive event in the same cycle as its clear write must win
		fork
			i_cpu.wr_reg(8'h07, 8'h08);
			begin
				step(1);
				rx = 1'h1;
				step(1);
				rx = 1'h0;
			end
		join
		chk({2'h0, rq}, 8'h0B);
		// reset in mid-run
		rst_i = 1'h1;
		step(1);
		chk({2'h0, en}, 8'h00);
		chk({prim, irq, rq}, 8'h00);
		rst_i = 1'h0;
		step(1);
		chk({full, empty, rq}, 8'h00);
		rd_chk(8'h06, 8'h00);
		finish_test;
	end
endmodule
`default_nettype wire
